// *** bench/awce_media_model.sv ***
`timescale 1ns/1ps
module awce_media_model #(
  parameter int DELAY = 3
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic sec_prog_i,
  input wire logic [27:0] sec_lba_i,
  input wire logic [9:0] fail_at_i,
  output logic sec_done_o,
  output logic sec_err_o,
  output logic [9:0] prog_cnt_o,
  output logic [27:0] last_lba_o
);
  int wait_q;
  // err toggles while unqualified so a design that reads it early sees noise
  always @(posedge clock_i)
  begin
    sec_done_o <= 1'b0;
    sec_err_o <= ~sec_err_o;
    if (srst_i)
    begin
      wait_q <= 0;
      sec_err_o <= 1'b0;
      prog_cnt_o <= '0;
      last_lba_o <= '0;
    end
    else if (sec_prog_i)
    begin
      wait_q <= DELAY;
      prog_cnt_o <= prog_cnt_o + 10'h001;
      last_lba_o <= sec_lba_i;
    end
    else if (wait_q == 1)
    begin
      wait_q <= 0;
      sec_done_o <= 1'b1;
      sec_err_o <= (prog_cnt_o == fail_at_i);
    end
    else if (wait_q > 1)
      wait_q <= wait_q - 1;
  end
endmodule

// *** bench/test_ata_write_command_engine.sv ***
`timescale 1ns/1ps
module test_ata_write_command_engine;
  localparam int WORDS = 4;
  logic clock_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0] reg_addr_i = '0;
  logic [15:0] reg_wdata_i = '0, reg_rdata_o, sec_wdata_o, rdata;
  logic intrq_o, busy_flag_o, data_request_flag_o, sec_wvalid_o, sec_prog_o, sec_erase_o, sec_verify_o;
  logic lin_o, done, err;
  logic [27:0] sec_lba_o, last_lba;
  logic [9:0] prog_cnt, fail_at = '0;
  int miscompares = 0, tests_run = 0, cyc = 0;
  int wv_cnt = 0;
  logic [15:0] wv_last = '0;
  logic [7:0] row_cmd [8] = '{8'hc5, 8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38, 8'h3c, 8'h30};
  logic [7:0] row_cnt [8] = '{8'h08, 8'h07, 8'h05, 8'h03, 8'h01, 8'h02, 8'h02, 8'h00};
  logic [7:0] row_blk [8] = '{8'h04, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
  logic [7:0] row_er = 8'b11011011;
  logic [7:0] row_vf = 8'b01000000;

  always #10 clock_i = ~clock_i;

  // words handed to the media side
  always @(posedge clock_i)
  begin
    if (sec_wvalid_o === 1'b1)
    begin
      wv_cnt <= wv_cnt + 1;
      wv_last <= sec_wdata_o;
    end
  end

  awce_engine #(.WORDS(WORDS)) dut_u (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .intrq_o(intrq_o), .busy_flag_o(busy_flag_o), .data_request_flag_o(data_request_flag_o),
    .sec_wdata_o(sec_wdata_o), .sec_wvalid_o(sec_wvalid_o), .sec_prog_o(sec_prog_o), .sec_lba_o(sec_lba_o),
    .sec_erase_o(sec_erase_o), .sec_verify_o(sec_verify_o), .linear_addressing_select_o(lin_o),
    .sec_done_i(done), .sec_err_i(err));

  awce_media_model #(.DELAY(3)) media_u (.clock_i(clock_i), .srst_i(srst_i), .sec_prog_i(sec_prog_o),
    .sec_lba_i(sec_lba_o), .fail_at_i(fail_at), .sec_done_o(done), .sec_err_o(err),
    .prog_cnt_o(prog_cnt), .last_lba_o(last_lba));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(string name, logic [27:0] got, logic [27:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 rdata = reg_rdata_o;
  endtask

  // bounded wait for a data request or the end of the command
  task automatic wait_rdy();
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clock_i);
      #1;
      if (data_request_flag_o === 1'b1 || busy_flag_o === 1'b0)
        break;
    end
  endtask

  task automatic run(logic [7:0] cmd, logic [7:0] cnt, logic [7:0] blk, logic er, logic vf, int fail);
    logic [27:0] linear_addressing_select;
    logic [9:0] base;
    logic blkc;
    int total, left, bursts, n, exp_sec, exp_b, words, wbase;
    logic [15:0] last_d;
    linear_addressing_select = 28'h7a3c1f0;
    blkc = (cmd == 8'hc5 || cmd == 8'hcd);
    total = (cnt == 8'h00) ? 256 : int'(cnt);
    exp_sec = (fail > 0) ? fail : total;
    exp_b = blkc ? (exp_sec + blk - 1) / blk : exp_sec;
    base = prog_cnt;
    fail_at = (fail > 0) ? base + 10'(fail) : 10'h000;
    left = total;
    bursts = 0;
    words = 0;
    wbase = wv_cnt;
    last_d = '0;
    wr(awce_pkg::REG_BLKSZ, {8'h00, blk});
    wr(awce_pkg::REG_SCNT, {8'h00, cnt});
    wr(awce_pkg::REG_SNUM, {8'h00, linear_addressing_select[7:0]});
    wr(awce_pkg::REG_CLO, {8'h00, linear_addressing_select[15:8]});
    wr(awce_pkg::REG_CHI, {8'h00, linear_addressing_select[23:16]});
    wr(awce_pkg::REG_DRVHD, {8'h00, 4'he, linear_addressing_select[27:24]});
    wr(awce_pkg::REG_CMD, {8'h00, cmd});
    while (left > 0)
    begin
      wait_rdy();
      if (data_request_flag_o !== 1'b1)
        break;
      chk("intrq at request", intrq_o, blkc);
      chk("erase", sec_erase_o, er);
      chk("verify", sec_verify_o, vf);
      n = blkc ? ((blk < left) ? blk : left) : 1;
      rd(awce_pkg::REG_CMD);
      repeat (n * WORDS) wr(awce_pkg::REG_DATA, 16'(left));
      last_d = 16'(left);
      words += n * WORDS;
      left -= n;
      bursts++;
      @(posedge clock_i);
    end
    wait_rdy();
    chk("bursts", bursts, exp_b);
    chk("sectors", prog_cnt - base, exp_sec);
    chk("intrq at end", intrq_o, 1);
    chk("linear", lin_o, 1);
    chk("words", wv_cnt - wbase, words);
    chk("last word", wv_last, last_d);
    rd(awce_pkg::REG_CMD);
    if (fail > 0)
    begin
      chk("status err", rdata[0], 1);
      rd(awce_pkg::REG_FEAT);
      chk("write fail", rdata[4], 1);
      rd(awce_pkg::REG_SCNT);
      chk("residual", rdata[7:0], total - fail + 1);
      rd(awce_pkg::REG_SNUM);
      chk("fail addr", rdata[7:0], 8'(linear_addressing_select[7:0] + fail - 1));
    end
    else
    begin
      chk("status", rdata[7:0], 8'h40);
      chk("last address", last_lba, linear_addressing_select + 28'(total - 1));
    end
    $display("test cmd %0h count %0d done", cmd, total);
  endtask

  initial
  begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    chk("intrq after reset", intrq_o, 0);
    rd(awce_pkg::REG_CMD);
    chk("reset status", rdata, 16'h0040);
    rd(awce_pkg::REG_BLKSZ);
    chk("reset block size", rdata, 16'h0000);
    rd(4'hf);
    chk("unmapped", rdata, 16'h0000);
    $display("test reset done");
    for (int r = 0; r < 8; r++)
      run(row_cmd[r], row_cnt[r], row_blk[r], row_er[r], row_vf[r], 0);
    // unset block size, block writes disabled, then an unknown code
    for (int k = 0; k < 3; k++)
    begin
      wr(awce_pkg::REG_CTRL, (k == 1) ? 16'h0000 : 16'h0001);
      wr(awce_pkg::REG_BLKSZ, (k == 0) ? 16'h0000 : 16'h0002);
      wr(awce_pkg::REG_CMD, (k == 2) ? 16'h0077 : {8'h00, awce_pkg::CMD_BLK_WR});
      wait_rdy();
      chk("abort request", data_request_flag_o, 0);
      chk("abort busy", busy_flag_o, 0);
      chk("abort intrq", intrq_o, 1);
      rd(awce_pkg::REG_FEAT);
      chk("abort bit", rdata[2], 1);
      $display("test abort %0d done", k);
    end
    wr(awce_pkg::REG_CTRL, 16'h0001);
    run(8'hc5, 8'h08, 8'h04, 1'b1, 1'b0, 3);
    run(8'h30, 8'h03, 8'h02, 1'b1, 1'b0, 2);
    // reset in the middle of a sector transfer
    wr(awce_pkg::REG_SCNT, 16'h0002);
    wr(awce_pkg::REG_CMD, {8'h00, awce_pkg::CMD_SEC_WR});
    wait_rdy();
    wr(awce_pkg::REG_DATA, 16'h00a5);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    chk("mid reset request", data_request_flag_o, 0);
    chk("mid reset busy", busy_flag_o, 0);
    chk("mid reset valid", sec_wvalid_o, 0);
    rd(awce_pkg::REG_SCNT);
    chk("mid reset count", rdata, 16'h0000);
    rd(awce_pkg::REG_CMD);
    chk("mid reset status", rdata, 16'h0040);
    $display("test mid reset done");
    stop_test();
  end
endmodule

// *** design/awce_engine.sv ***
// Overview of operation
// - busy raised within 400 ns of block write
// - block write interrupts per block, not sector
// - data request checked only at block start
// - sector count means sectors, not blocks
// - full blocks first, then remainder block
// - abort block write if unset or disabled
// - error after block attempt, stop at sector
// - interrupt when data request opens block
// - error leaves failing address, residual count
// - code cdh is block write without erase
// - code 38h is sector write without erase
// - sector write count 1..256, zero means 256
// - start at address in task file
// - busy, then request; no first interrupt
// - busy between sectors, interrupt at completion
// - on error stop, keep failing address
// - code 3ch verifies each written sector
// - linear address split over four registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module awce_engine #(
  parameter int WORDS = awce_pkg::WORDS_PER_SECTOR
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic intrq_o,
  output logic busy_flag_o,
  output logic data_request_flag_o,
  output logic [15:0] sec_wdata_o,
  output logic sec_wvalid_o,
  output logic sec_prog_o,
  output logic [27:0] sec_lba_o,
  output logic sec_erase_o,
  output logic sec_verify_o,
  output logic linear_addressing_select_o,
  input wire logic sec_done_i,
  input wire logic sec_err_i
);
  if (WORDS < 2 || WORDS > 256)
  begin : g_chk
    $error("awce_engine: WORDS must lie in 2..256");
  end

  typedef struct packed {
    awce_pkg::awce_state_e st;
    logic busy;
    logic data_request_flag;
    logic errst;
    logic intrq;
    logic [7:0] errreg;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] clo;
    logic [7:0] chi;
    logic [7:0] dh;
    logic [7:0] blksz;
    logic [7:0] ctrl;
    logic blk;
    logic erase;
    logic verify;
    logic [27:0] linear_addressing_select;
    logic [8:0] remain;
    logic [8:0] blk_left;
    logic [8:0] xcnt;
    logic [8:0] wcnt;
    logic [15:0] rdata;
    logic [15:0] wdata;
    logic wvalid;
    logic prog;
  } awce_regs_s;

  localparam awce_regs_s REGS_RESET = '{
    st: awce_pkg::S_IDLE, busy: 1'b0, data_request_flag: 1'b0, errst: 1'b0, intrq: 1'b0,
    errreg: awce_pkg::TF_RESET, scnt: awce_pkg::TF_RESET, snum: awce_pkg::TF_RESET,
    clo: awce_pkg::TF_RESET, chi: awce_pkg::TF_RESET, dh: awce_pkg::TF_RESET,
    blksz: awce_pkg::BLKSZ_RESET, ctrl: awce_pkg::CTRL_RESET,
    blk: 1'b0, erase: 1'b0, verify: 1'b0, linear_addressing_select: 28'h0000000,
    remain: 9'h000, blk_left: 9'h000, xcnt: 9'h000, wcnt: 9'h000,
    rdata: 16'h0000, wdata: 16'h0000, wvalid: 1'b0, prog: 1'b0};

  localparam logic [8:0] WORDS_LAST = 9'(WORDS - 1);

  awce_regs_s r_r;
  awce_regs_s r_nxt;
  logic [7:0] cmd;
  logic is_blk;
  logic is_sec;
  logic cmd_wr;
  logic [7:0] status;

  assign cmd = reg_wdata_i[7:0];
  assign is_blk = (cmd == awce_pkg::CMD_BLK_WR) || (cmd == awce_pkg::CMD_BLK_WR_NE);
  assign is_sec = (cmd == awce_pkg::CMD_SEC_WR) || (cmd == awce_pkg::CMD_SEC_WR_R) ||
                  (cmd == awce_pkg::CMD_SEC_WR_NE) || (cmd == awce_pkg::CMD_WR_VFY);
  // commands written while the engine is working are ignored
  assign cmd_wr = reg_wr_i && (reg_addr_i == awce_pkg::REG_CMD) && (r_r.st == awce_pkg::S_IDLE);

  always_comb
  begin
    status = 8'h00;
    status[awce_pkg::SB_BUSY] = r_r.busy;
    status[awce_pkg::SB_READY] = ~r_r.busy;
    status[awce_pkg::SB_DRQ] = r_r.data_request_flag;
    status[awce_pkg::SB_ERR] = r_r.errst;
  end

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.wvalid = 1'b0;
    r_nxt.prog = 1'b0;
    r_nxt.rdata = 16'h0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        awce_pkg::REG_FEAT: r_nxt.rdata = {8'h00, r_r.errreg};
        awce_pkg::REG_SCNT: r_nxt.rdata = {8'h00, r_r.scnt};
        awce_pkg::REG_SNUM: r_nxt.rdata = {8'h00, r_r.snum};
        awce_pkg::REG_CLO: r_nxt.rdata = {8'h00, r_r.clo};
        awce_pkg::REG_CHI: r_nxt.rdata = {8'h00, r_r.chi};
        awce_pkg::REG_DRVHD: r_nxt.rdata = {8'h00, r_r.dh};
        awce_pkg::REG_CMD: r_nxt.rdata = {8'h00, status};
        awce_pkg::REG_BLKSZ: r_nxt.rdata = {8'h00, r_r.blksz};
        awce_pkg::REG_CTRL: r_nxt.rdata = {8'h00, r_r.ctrl};
        default: r_nxt.rdata = 16'h0000;
      endcase
      // reading status acknowledges the pending interrupt
      if (reg_addr_i == awce_pkg::REG_CMD)
      begin
        r_nxt.intrq = 1'b0;
      end
    end
    // task file is frozen while a command runs so the host cannot corrupt it
    if (reg_wr_i && r_r.st == awce_pkg::S_IDLE)
    begin
      case (reg_addr_i)
        awce_pkg::REG_SCNT: r_nxt.scnt = reg_wdata_i[7:0];
        awce_pkg::REG_SNUM: r_nxt.snum = reg_wdata_i[7:0];
        awce_pkg::REG_CLO: r_nxt.clo = reg_wdata_i[7:0];
        awce_pkg::REG_CHI: r_nxt.chi = reg_wdata_i[7:0];
        awce_pkg::REG_DRVHD: r_nxt.dh = reg_wdata_i[7:0];
        awce_pkg::REG_BLKSZ: r_nxt.blksz = reg_wdata_i[7:0];
        awce_pkg::REG_CTRL: r_nxt.ctrl = reg_wdata_i[7:0];
        default: r_nxt.ctrl = r_r.ctrl;
      endcase
    end
    case (r_r.st)
      awce_pkg::S_IDLE:
      begin
        if (cmd_wr)
        begin
          r_nxt.intrq = 1'b0;
          r_nxt.errreg = 8'h00;
          r_nxt.errst = 1'b0;
          if ((is_blk && (r_r.blksz == 8'h00 || !r_r.ctrl[awce_pkg::CTRL_BLK_EN])) || !(is_blk || is_sec))
          begin
            r_nxt.errreg[awce_pkg::ER_ABORT] = 1'b1;
            r_nxt.errst = 1'b1;
            r_nxt.intrq = 1'b1;
          end
          else
          begin
            r_nxt.busy = 1'b1;
            r_nxt.st = awce_pkg::S_SETUP;
            r_nxt.blk = is_blk;
            r_nxt.erase = !(cmd == awce_pkg::CMD_BLK_WR_NE || cmd == awce_pkg::CMD_SEC_WR_NE);
            r_nxt.verify = (cmd == awce_pkg::CMD_WR_VFY);
            r_nxt.linear_addressing_select = {r_r.dh[3:0], r_r.chi, r_r.clo, r_r.snum};
            r_nxt.remain = (r_r.scnt == 8'h00) ? awce_pkg::MAX_SECTORS : {1'b0, r_r.scnt};
          end
        end
      end
      awce_pkg::S_SETUP:
      begin
        r_nxt.data_request_flag = 1'b1;
        r_nxt.busy = 1'b0;
        r_nxt.wcnt = 9'h000;
        r_nxt.xcnt = 9'h000;
        r_nxt.st = awce_pkg::S_XFER;
        if (r_r.blk)
        begin
          // full block while enough sectors remain, else the remainder
          r_nxt.blk_left = ({1'b0, r_r.blksz} > r_r.remain) ? r_r.remain : {1'b0, r_r.blksz};
          r_nxt.intrq = 1'b1;
        end
        else
        begin
          r_nxt.blk_left = 9'h001;
        end
      end
      awce_pkg::S_XFER:
      begin
        // request stays up for the whole block; host need not re-poll
        if (reg_wr_i && reg_addr_i == awce_pkg::REG_DATA)
        begin
          r_nxt.wvalid = 1'b1;
          r_nxt.wdata = reg_wdata_i;
          r_nxt.wcnt = r_r.wcnt + 9'h001;
          if (r_r.wcnt == WORDS_LAST)
          begin
            r_nxt.wcnt = 9'h000;
            r_nxt.xcnt = r_r.xcnt + 9'h001;
            if (r_r.xcnt + 9'h001 == r_r.blk_left)
            begin
              r_nxt.data_request_flag = 1'b0;
              r_nxt.busy = 1'b1;
              r_nxt.st = awce_pkg::S_PROG;
            end
          end
        end
      end
      awce_pkg::S_PROG:
      begin
        r_nxt.prog = 1'b1;
        r_nxt.st = awce_pkg::S_WAIT;
        r_nxt.snum = r_r.linear_addressing_select[7:0];
        r_nxt.clo = r_r.linear_addressing_select[15:8];
        r_nxt.chi = r_r.linear_addressing_select[23:16];
        r_nxt.dh = {r_r.dh[7:4], r_r.linear_addressing_select[27:24]};
        r_nxt.scnt = r_r.remain[7:0];
      end
      awce_pkg::S_WAIT:
      begin
        if (sec_done_i && sec_err_i)
        begin
          // remaining sectors of the block are dropped
          r_nxt.errst = 1'b1;
          r_nxt.errreg[awce_pkg::ER_WRFAIL] = 1'b1;
          r_nxt.busy = 1'b0;
          r_nxt.intrq = 1'b1;
          r_nxt.st = awce_pkg::S_IDLE;
        end
        else if (sec_done_i)
        begin
          r_nxt.linear_addressing_select = r_r.linear_addressing_select + 28'h0000001;
          r_nxt.remain = r_r.remain - 9'h001;
          r_nxt.blk_left = r_r.blk_left - 9'h001;
          r_nxt.scnt = 8'(r_r.remain - 9'h001);
          if (r_r.remain == 9'h001)
          begin
            r_nxt.busy = 1'b0;
            r_nxt.intrq = 1'b1;
            r_nxt.st = awce_pkg::S_IDLE;
          end
          else if (r_r.blk_left == 9'h001)
          begin
            r_nxt.st = awce_pkg::S_SETUP;
          end
          else
          begin
            r_nxt.st = awce_pkg::S_PROG;
          end
        end
      end
      default: r_nxt = REGS_RESET;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      r_r <= REGS_RESET;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata_o = r_r.rdata;
  assign intrq_o = r_r.intrq;
  assign busy_flag_o = r_r.busy;
  assign data_request_flag_o = r_r.data_request_flag;
  assign sec_wdata_o = r_r.wdata;
  assign sec_wvalid_o = r_r.wvalid;
  assign sec_prog_o = r_r.prog;
  // address counts linearly in either mode; no geometry wrap is applied
  assign sec_lba_o = r_r.linear_addressing_select;
  assign sec_erase_o = r_r.erase;
  assign sec_verify_o = r_r.verify;
  assign linear_addressing_select_o = r_r.dh[awce_pkg::DH_LBA];

  localparam int busy_lim = awce_pkg::BUSY_CYC;
  logic acc_ok;
  assign acc_ok = cmd_wr && (is_sec || (is_blk && r_r.blksz != 8'h00 && r_r.ctrl[awce_pkg::CTRL_BLK_EN]));

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  sequence sec_accept_s;
    cmd_wr && is_sec;
  endsequence
  sequence busy_then_req_s;
    busy_flag_o && !data_request_flag_o ##1 data_request_flag_o && !busy_flag_o && !intrq_o;
  endsequence

  busy_rise_a: assert property (acc_ok |-> ##[1:busy_lim] busy_flag_o)
    else $error("busy not raised in time");
  first_no_int_a: assert property (sec_accept_s |=> busy_then_req_s)
    else $error("sector write start sequence wrong");
  abort_a: assert property (cmd_wr && is_blk && r_r.blksz == 8'h00 |=>
    r_r.errst && r_r.errreg[awce_pkg::ER_ABORT] && !busy_flag_o && intrq_o)
    else $error("block write without block size not aborted");
  block_int_a: assert property ($rose(data_request_flag_o) |-> intrq_o == r_r.blk)
    else $error("block start interrupt wrong");
  partial_a: assert property ($rose(data_request_flag_o) && r_r.blk |->
    r_r.blk_left == (({1'b0, r_r.blksz} > r_r.remain) ? r_r.remain : {1'b0, r_r.blksz}))
    else $error("block length wrong");
  count_zero_a: assert property (acc_ok && r_r.scnt == 8'h00 |=> r_r.remain == 9'h100)
    else $error("zero count not 256");
  start_addr_a: assert property (acc_ok |=>
    r_r.linear_addressing_select == {$past(r_r.dh[3:0]), $past(r_r.chi), $past(r_r.clo), $past(r_r.snum)})
    else $error("start address wrong");
  req_drop_a: assert property ($fell(data_request_flag_o) |-> busy_flag_o || r_r.st == awce_pkg::S_IDLE)
    else $error("request dropped without busy");
  done_int_a: assert property (r_r.st == awce_pkg::S_WAIT && sec_done_i && !sec_err_i && r_r.remain == 9'h001
    |=> !busy_flag_o && intrq_o && !data_request_flag_o)
    else $error("completion not signalled");
  err_stop_a: assert property (r_r.st == awce_pkg::S_WAIT && sec_done_i && sec_err_i |=>
    r_r.errst && !busy_flag_o && r_r.snum == $past(r_r.linear_addressing_select[7:0]) && r_r.scnt == $past(r_r.remain[7:0])
    ##1 !sec_prog_o [*2])
    else $error("error did not stop at failing sector");

  sequence blk_open_s;
    data_request_flag_o && !busy_flag_o && intrq_o;
  endsequence
  sequence sec_write_s;
    sec_prog_o && busy_flag_o && !data_request_flag_o;
  endsequence

  open_int_a: assert property (r_r.st == awce_pkg::S_SETUP && r_r.blk |=> blk_open_s)
    else $error("block start not signalled");
  sec_open_a: assert property (r_r.st == awce_pkg::S_SETUP && !r_r.blk |=> data_request_flag_o && !intrq_o)
    else $error("sector start raised an interrupt");
  req_hold_a: assert property (data_request_flag_o &&
    !(reg_wr_i && reg_addr_i == awce_pkg::REG_DATA) |=> data_request_flag_o)
    else $error("request dropped inside a block");
  flag_excl_a: assert property (!(busy_flag_o && data_request_flag_o))
    else $error("busy and request both set");
  prog_busy_a: assert property (r_r.st == awce_pkg::S_PROG |=> sec_write_s)
    else $error("sector program without busy");
  word_pass_a: assert property (r_r.st == awce_pkg::S_XFER && reg_wr_i &&
    reg_addr_i == awce_pkg::REG_DATA |=> sec_wvalid_o && sec_wdata_o == $past(reg_wdata_i))
    else $error("data word not passed on");
  word_idle_a: assert property (r_r.st != awce_pkg::S_XFER |=> !sec_wvalid_o)
    else $error("data word outside a request");
  prog_addr_a: assert property (r_r.st == awce_pkg::S_PROG |=>
    {r_r.dh[3:0], r_r.chi, r_r.clo, r_r.snum} == $past(r_r.linear_addressing_select) && r_r.scnt == $past(r_r.remain[7:0]))
    else $error("task file not tracking sector");
  no_erase_a: assert property (acc_ok && (cmd == awce_pkg::CMD_BLK_WR_NE ||
    cmd == awce_pkg::CMD_SEC_WR_NE) |=> !sec_erase_o)
    else $error("erase not skipped");
  verify_a: assert property (acc_ok |=> sec_verify_o == ($past(cmd) == awce_pkg::CMD_WR_VFY))
    else $error("verify mode wrong");
  count_sec_a: assert property (acc_ok && r_r.scnt != 8'h00 |=> r_r.remain == {1'b0, $past(r_r.scnt)})
    else $error("count not taken as sectors");
  abort_off_a: assert property (cmd_wr && is_blk && !r_r.ctrl[awce_pkg::CTRL_BLK_EN] |=>
    r_r.errreg[awce_pkg::ER_ABORT] && !busy_flag_o && !data_request_flag_o && intrq_o)
    else $error("disabled block write not aborted");
  // only two quiet cycles: a fresh command may legally raise a request on the third
  err_halt_a: assert property (r_r.st == awce_pkg::S_WAIT && sec_done_i && sec_err_i |=>
    !data_request_flag_o [*2])
    else $error("transfer went on after error");
endmodule

// *** design/awce_pkg.sv ***
package awce_pkg;
  // task file offsets; reads of feature and command return error and status
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_FEAT = 4'h1;
  localparam logic [3:0] REG_SCNT = 4'h2;
  localparam logic [3:0] REG_SNUM = 4'h3;
  localparam logic [3:0] REG_CLO = 4'h4;
  localparam logic [3:0] REG_CHI = 4'h5;
  localparam logic [3:0] REG_DRVHD = 4'h6;
  localparam logic [3:0] REG_CMD = 4'h7;
  localparam logic [3:0] REG_BLKSZ = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'h9;

  localparam logic [7:0] CMD_BLK_WR = 8'hc5;
  localparam logic [7:0] CMD_BLK_WR_NE = 8'hcd;
  localparam logic [7:0] CMD_SEC_WR = 8'h30;
  localparam logic [7:0] CMD_SEC_WR_R = 8'h31;
  localparam logic [7:0] CMD_SEC_WR_NE = 8'h38;
  localparam logic [7:0] CMD_WR_VFY = 8'h3c;

  localparam int SB_BUSY = 7;
  localparam int SB_READY = 6;
  localparam int SB_DRQ = 3;
  localparam int SB_ERR = 0;
  localparam int ER_ABORT = 2;
  localparam int ER_WRFAIL = 4;
  localparam int DH_LBA = 6;
  localparam int CTRL_BLK_EN = 0;

  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] BLKSZ_RESET = 8'h00;
  localparam logic [7:0] TF_RESET = 8'h00;

  localparam int CLK_NS = 20;
  localparam int BUSY_MAX_NS = 400;
  localparam int BUSY_CYC = (BUSY_MAX_NS / CLK_NS < 1) ? 1 : BUSY_MAX_NS / CLK_NS;
  localparam int WORDS_PER_SECTOR = 256;
  localparam logic [8:0] MAX_SECTORS = 9'h100;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SETUP = 5'b00010,
    S_XFER = 5'b00100,
    S_PROG = 5'b01000,
    S_WAIT = 5'b10000
  } awce_state_e;
endpackage
